/* logic/umc_pkg.sv */
// package for the serial mode-control block: offsets, fields, types
package umc_pkg;
  // register byte offsets
  localparam logic [3:0] UMC_MODE_OFS   = 4'h0;
  localparam logic [3:0] UMC_STAT_OFS   = 4'h4;
  localparam logic [3:0] UMC_IRQ_OFS    = 4'h8;
  localparam logic [3:0] UMC_MASK_OFS   = 4'hC;
  // mode register field positions
  localparam int UMC_EN_BIT     = 15;
  localparam int UMC_SIDL_BIT   = 13;
  localparam int UMC_IR_BIT     = 12;
  localparam int UMC_RTSMODE_BIT = 11;
  localparam int UMC_PINSEL_LO  = 8;
  localparam int UMC_WAKE_BIT   = 7;
  localparam int UMC_LOOP_BIT   = 6;
  localparam int UMC_ABD_BIT    = 5;
  // writable bits of the mode register; 14 and 10 are not implemented
  localparam logic [15:0] UMC_MODE_WMASK = 16'hBBFF;
  localparam logic [15:0] UMC_MODE_RST   = 16'h0000;
  localparam logic [2:0]  UMC_IRQ_RST    = 3'h0;
  // interrupt status bit positions
  localparam int UMC_IRQ_WAKE  = 0;
  localparam int UMC_IRQ_ABD   = 1;
  localparam int UMC_IRQ_ABERR = 2;
  // auto-rate sync character and edge count (0x55 gives 5 falling edges)
  localparam logic [7:0] UMC_SYNC_CHAR  = 8'h55;
  localparam logic [2:0] UMC_SYNC_EDGES = 3'h5;
  // pin-enable selections
  localparam logic [1:0] UMC_PINS_TXRX  = 2'h0;
  localparam logic [1:0] UMC_PINS_RTS   = 2'h1;
  localparam logic [1:0] UMC_PINS_FLOW  = 2'h2;
  localparam logic [1:0] UMC_PINS_BCLK  = 2'h3;

  typedef enum logic [2:0] {
    UMC_AB_IDLE  = 3'b001,
    UMC_AB_COUNT = 3'b010,
    UMC_AB_DONE  = 3'b100
  } umc_ab_state_type;

  // pin ownership bundle toward the pad ring
  typedef struct packed {
    logic tx_own;
    logic rx_own;
    logic cts_own;
    logic rts_own;
    logic bclk_own;
  } umc_pin_own_type;
endpackage

/* logic/umc_mode_ctrl.sv */
// mode-control logic of the asynchronous serial port
//
// Summary of operation
// - enable bit hands pins to serial module
// - disabled: pins to port latches, low power
// - bits 14 and 10 read zero
// - stop-in-idle halts module during idle
// - infrared bit enables encoder and decoder, not in high-speed mode
// - request pin simplex or flow-control mode
// - select 11: tx, rx, baud clock
// - select 10: tx, rx, cts, rts
// - select 01: tx, rx, rts
// - select 00: tx and rx only
// - wake bit samples rx, irq on fall while asleep
// - wake bit clears on following rise
// - loopback bit selects loopback mode
// - auto-rate measures next 0x55 character
// - auto-rate bit reads zero when done
// - hardware clears wake and auto-rate; reset zero
`timescale 1ns/100ps
`default_nettype none
module umc_mode_ctrl
  import umc_pkg::*;
#(
  parameter int CNT_W = 20
) (
  // clock and reset
  input  wire logic                  I_CLK,
  input  wire logic                  I_SYS_RST,
  // wishbone slave
  input  wire logic                  I_WB_CYC,
  input  wire logic                  I_WB_STB,
  input  wire logic                  I_WB_WE,
  input  wire logic [3:0]            I_WB_ADR,
  input  wire logic [3:0]            I_WB_SEL,
  input  wire logic [31:0]           I_WB_DAT,
  output logic      [31:0]           O_WB_DAT,
  output logic                       O_WB_ACK,
  output logic                       O_WB_ERR,
  // power state of the device
  input  wire logic                  I_IDLE,
  input  wire logic                  I_SLEEP,
  // serial datapath side
  input  wire logic                  I_CORE_TX,
  input  wire logic                  I_CORE_RTS,
  input  wire logic                  I_CORE_BCLK,
  input  wire logic                  I_HIGH_SPEED_RATE_SELECT,
  output logic                       O_CORE_RX,
  output logic                       O_CORE_CTS,
  output logic                       O_CORE_RUN,
  output logic                       O_INFRARED_CODEC_ENABLE,
  output logic                       O_REQUEST_PIN_MODE,
  output logic                       O_LOOPBACK_SELECT,
  output logic [CNT_W-1:0]           O_RATE_COUNT,
  // pins
  input  wire logic                  I_SERIAL_RECEIVE_PIN,
  input  wire logic                  I_CLEAR_TO_SEND_PIN,
  output logic                       O_SERIAL_TRANSMIT_PIN,
  output logic                       O_REQUEST_TO_SEND_PIN,
  output umc_pin_own_type            O_PIN_OWN,
  // interrupt
  output logic                       O_IRQ
);

  logic [15:0]      mode_reg, mode_next;
  logic [2:0]       irq_reg, irq_next;
  logic [2:0]       mask_reg, mask_next;
  logic             ack_reg, ack_next;
  logic             err_reg, err_next;
  logic [31:0]      rdat_reg, rdat_next;
  logic [1:0]       rx_sync_reg, cts_sync_reg;
  logic             rx_last_reg;
  logic             wake_arm_reg, wake_arm_next;
  umc_ab_state_type ab_reg, ab_next;
  logic [2:0]       edge_reg, edge_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] rate_reg, rate_next;

  logic             rx_s, rx_in, rx_fall, rx_rise;
  logic             bus_req, wr_en, rd_hit;
  logic [2:0]       irq_set;
  logic             wake_clr, abd_clr;

  // bus offset decode, used for reads and writes
  function automatic logic is_ofs(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction

  assign bus_req = I_WB_CYC && I_WB_STB && !ack_reg && !err_reg;
  assign wr_en   = bus_req && I_WB_WE;
  assign rd_hit  = is_ofs(I_WB_ADR, UMC_MODE_OFS) ||
                   is_ofs(I_WB_ADR, UMC_STAT_OFS) ||
                   is_ofs(I_WB_ADR, UMC_IRQ_OFS)  ||
                   is_ofs(I_WB_ADR, UMC_MASK_OFS);

  // receive pin and cts synchronisers; rx_s is the second stage
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rx_sync_reg  <= 2'h3;
      cts_sync_reg <= 2'h3;
      rx_last_reg  <= 1'b1;
    end else begin
      rx_sync_reg  <= {rx_sync_reg[0], I_SERIAL_RECEIVE_PIN};
      cts_sync_reg <= {cts_sync_reg[0], I_CLEAR_TO_SEND_PIN};
      rx_last_reg  <= rx_in;
    end
  end
  assign rx_s = rx_sync_reg[1];

  // loopback feeds the transmitter into the receiver, pin ignored
  assign rx_in   = mode_reg[UMC_LOOP_BIT] ? I_CORE_TX : rx_s;
  assign rx_fall = rx_last_reg && !rx_in;
  assign rx_rise = !rx_last_reg && rx_in;

  // pin ownership per selection; all pins to port latches when disabled
  always_comb begin
    O_PIN_OWN = '0;
    if (mode_reg[UMC_EN_BIT]) begin
      O_PIN_OWN.tx_own = 1'b1;
      O_PIN_OWN.rx_own = 1'b1;
      unique case (mode_reg[UMC_PINSEL_LO +: 2])
        UMC_PINS_TXRX: ;
        UMC_PINS_RTS:  O_PIN_OWN.rts_own = 1'b1;
        UMC_PINS_FLOW: begin
          O_PIN_OWN.cts_own = 1'b1;
          O_PIN_OWN.rts_own = 1'b1;
        end
        UMC_PINS_BCLK: O_PIN_OWN.bclk_own = 1'b1;
      endcase
    end
  end

  // the pad ring uses O_PIN_OWN to pick between these and port latches
  assign O_SERIAL_TRANSMIT_PIN = O_PIN_OWN.tx_own ? I_CORE_TX : 1'b1;
  assign O_REQUEST_TO_SEND_PIN = O_PIN_OWN.bclk_own ? I_CORE_BCLK :
                                 O_PIN_OWN.rts_own ? I_CORE_RTS : 1'b1;
  assign O_CORE_RX  = rx_in;
  assign O_CORE_CTS = O_PIN_OWN.cts_own ? cts_sync_reg[1] : 1'b0;
  // run only when enabled and not stopped by idle
  assign O_CORE_RUN = mode_reg[UMC_EN_BIT] &&
                      !(mode_reg[UMC_SIDL_BIT] && I_IDLE);
  // software keeps this clear in high-speed mode; gated here as well
  assign O_INFRARED_CODEC_ENABLE = mode_reg[UMC_IR_BIT] &&
                                   !I_HIGH_SPEED_RATE_SELECT;
  assign O_REQUEST_PIN_MODE = mode_reg[UMC_RTSMODE_BIT];
  assign O_LOOPBACK_SELECT  = mode_reg[UMC_LOOP_BIT];
  assign O_RATE_COUNT       = rate_reg;

  // wake detector: a falling edge while asleep arms, next rise clears
  always_comb begin
    wake_arm_next = wake_arm_reg;
    wake_clr      = 1'b0;
    irq_set       = '0;
    if (!mode_reg[UMC_WAKE_BIT]) begin
      wake_arm_next = 1'b0;
    end else if (!wake_arm_reg && rx_fall && I_SLEEP) begin
      wake_arm_next = 1'b1;
      irq_set[UMC_IRQ_WAKE] = 1'b1;
    end else if (wake_arm_reg && rx_rise) begin
      wake_arm_next = 1'b0;
      wake_clr      = 1'b1;
    end
    if (ab_reg == UMC_AB_DONE) begin
      irq_set[UMC_IRQ_ABD] = 1'b1;
    end
    if (ab_reg == UMC_AB_COUNT && &cnt_reg) begin
      irq_set[UMC_IRQ_ABERR] = 1'b1;
    end
  end

  // auto-rate: count clocks over the five falling edges of 0x55
  always_comb begin
    ab_next   = ab_reg;
    edge_next = edge_reg;
    cnt_next  = cnt_reg;
    rate_next = rate_reg;
    abd_clr   = 1'b0;
    unique case (ab_reg)
      UMC_AB_IDLE: begin
        edge_next = '0;
        cnt_next  = '0;
        if (mode_reg[UMC_ABD_BIT] && rx_fall) begin
          ab_next   = UMC_AB_COUNT;
          edge_next = 3'h1;
        end
      end
      UMC_AB_COUNT: begin
        cnt_next = cnt_reg + 1'b1;
        if (!mode_reg[UMC_ABD_BIT] || &cnt_reg) begin
          ab_next = UMC_AB_IDLE;
          abd_clr = 1'b1;
        end else if (rx_fall) begin
          edge_next = edge_reg + 3'h1;
          if (edge_reg + 3'h1 == UMC_SYNC_EDGES) begin
            ab_next   = UMC_AB_DONE;
            rate_next = cnt_reg + 1'b1;
          end
        end
      end
      UMC_AB_DONE: begin
        ab_next = UMC_AB_IDLE;
        abd_clr = 1'b1;
      end
      default: ab_next = UMC_AB_IDLE;
    endcase
  end

  // register file; hardware clear loses to a software write of one
  always_comb begin
    mode_next = mode_reg;
    irq_next  = irq_reg;
    mask_next = mask_reg;
    if (wake_clr) mode_next[UMC_WAKE_BIT] = 1'b0;
    if (abd_clr)  mode_next[UMC_ABD_BIT]  = 1'b0;
    if (wr_en && is_ofs(I_WB_ADR, UMC_MODE_OFS)) begin
      if (I_WB_SEL[0]) mode_next[7:0] = I_WB_DAT[7:0];
      if (I_WB_SEL[1]) mode_next[15:8] = I_WB_DAT[15:8];
      mode_next = mode_next & UMC_MODE_WMASK;
    end
    if (wr_en && I_WB_SEL[0] && is_ofs(I_WB_ADR, UMC_IRQ_OFS)) begin
      irq_next = irq_next & ~I_WB_DAT[2:0];
    end
    if (wr_en && I_WB_SEL[0] && is_ofs(I_WB_ADR, UMC_MASK_OFS)) begin
      mask_next = I_WB_DAT[2:0];
    end
    irq_next = irq_next | irq_set;
  end

  // bus answer one cycle after the request, error on unmapped offset
  always_comb begin
    ack_next  = bus_req && rd_hit;
    err_next  = bus_req && !rd_hit;
    rdat_next = rdat_reg;
    if (bus_req && !I_WB_WE) begin
      rdat_next = '0;
      if (is_ofs(I_WB_ADR, UMC_MODE_OFS)) begin
        rdat_next[15:0] = mode_reg & UMC_MODE_WMASK;
      end else if (is_ofs(I_WB_ADR, UMC_STAT_OFS)) begin
        rdat_next[3:0] = {O_CORE_RUN, wake_arm_reg,
                          ab_reg == UMC_AB_COUNT, rx_in};
      end else if (is_ofs(I_WB_ADR, UMC_IRQ_OFS)) begin
        rdat_next[2:0] = irq_reg;
      end else if (is_ofs(I_WB_ADR, UMC_MASK_OFS)) begin
        rdat_next[2:0] = mask_reg;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      mode_reg     <= UMC_MODE_RST;
      irq_reg      <= UMC_IRQ_RST;
      mask_reg     <= UMC_IRQ_RST;
      ack_reg      <= 1'b0;
      err_reg      <= 1'b0;
      rdat_reg     <= '0;
      wake_arm_reg <= 1'b0;
      ab_reg       <= UMC_AB_IDLE;
      edge_reg     <= '0;
      cnt_reg      <= '0;
      rate_reg     <= '0;
    end else begin
      mode_reg     <= mode_next;
      irq_reg      <= irq_next;
      mask_reg     <= mask_next;
      ack_reg      <= ack_next;
      err_reg      <= err_next;
      rdat_reg     <= rdat_next;
      wake_arm_reg <= wake_arm_next;
      ab_reg       <= ab_next;
      edge_reg     <= edge_next;
      cnt_reg      <= cnt_next;
      rate_reg     <= rate_next;
    end
  end

  assign O_WB_DAT = rdat_reg;
  assign O_WB_ACK = ack_reg;
  assign O_WB_ERR = err_reg;
  assign O_IRQ    = |(irq_reg & mask_reg);

  // checks
  reserved_zero_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[14] == 1'b0 && mode_reg[10] == 1'b0)
    else $error("reserved mode bit set");
  disabled_pins_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !mode_reg[UMC_EN_BIT] |-> O_PIN_OWN == '0 && !O_CORE_RUN)
    else $error("pins owned while disabled");
  enabled_pins_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[UMC_EN_BIT] |-> O_PIN_OWN.tx_own && O_PIN_OWN.rx_own)
    else $error("tx or rx not owned while enabled");
  flow_pins_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[UMC_EN_BIT] && mode_reg[9:8] == UMC_PINS_FLOW
    |-> O_PIN_OWN.cts_own && O_PIN_OWN.rts_own)
    else $error("flow selection missing pins");
  bclk_pins_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[UMC_EN_BIT] && mode_reg[9:8] == UMC_PINS_BCLK
    |-> O_PIN_OWN.bclk_own && !O_PIN_OWN.cts_own)
    else $error("baud clock selection wrong");
  rts_pins_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[UMC_EN_BIT] && mode_reg[9:8] == UMC_PINS_RTS
    |-> O_PIN_OWN.rts_own && !O_PIN_OWN.cts_own)
    else $error("rts selection wrong");
  idle_stop_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[UMC_SIDL_BIT] && I_IDLE |-> !O_CORE_RUN)
    else $error("running in idle");
  wake_irq_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[UMC_WAKE_BIT] && !wake_arm_reg && rx_fall && I_SLEEP
    |=> irq_reg[UMC_IRQ_WAKE] && wake_arm_reg)
    else $error("wake edge lost");
  wake_clear_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    wake_arm_reg && rx_rise && mode_reg[UMC_WAKE_BIT] && !wr_en
    |=> !mode_reg[UMC_WAKE_BIT])
    else $error("wake bit not cleared");
  abd_clear_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    ab_reg == UMC_AB_DONE && !wr_en |=> !mode_reg[UMC_ABD_BIT])
    else $error("auto-rate bit not cleared");
  loop_route_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[UMC_LOOP_BIT] |-> O_CORE_RX == I_CORE_TX)
    else $error("loopback not routed");
  ack_one_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held");
  // mode outputs, pin drive, wake arming, auto-rate start and abort, bus error
  ir_enable_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[UMC_IR_BIT] != O_INFRARED_CODEC_ENABLE |-> I_HIGH_SPEED_RATE_SELECT)
    else $error("infrared enable wrong");
  rts_mode_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_REQUEST_PIN_MODE == mode_reg[UMC_RTSMODE_BIT])
    else $error("request pin mode wrong");
  txrx_pins_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[UMC_EN_BIT] && mode_reg[9:8] == UMC_PINS_TXRX
    |-> !O_PIN_OWN.cts_own && !O_PIN_OWN.rts_own && !O_PIN_OWN.bclk_own)
    else $error("tx rx selection owns extra pins");
  run_through_idle_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    mode_reg[UMC_EN_BIT] && !mode_reg[UMC_SIDL_BIT] |-> O_CORE_RUN)
    else $error("stopped without stop-in-idle");
  loop_off_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !mode_reg[UMC_LOOP_BIT] |-> O_CORE_RX == rx_sync_reg[1])
    else $error("receiver not fed from pin");
  tx_pin_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_PIN_OWN.tx_own |-> O_SERIAL_TRANSMIT_PIN == I_CORE_TX)
    else $error("tx pin not driven by module");
  bclk_drive_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_PIN_OWN.bclk_own |-> O_REQUEST_TO_SEND_PIN == I_CORE_BCLK)
    else $error("baud clock not on shared pin");
  wake_sleep_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !I_SLEEP && !wake_arm_reg |=> !wake_arm_reg)
    else $error("wake armed while awake");
  abd_start_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    ab_reg == UMC_AB_IDLE && mode_reg[UMC_ABD_BIT] && rx_fall
    |=> ab_reg == UMC_AB_COUNT)
    else $error("auto-rate did not start");
  rate_ovf_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    ab_reg == UMC_AB_COUNT && &cnt_reg && !wr_en
    |=> irq_reg[UMC_IRQ_ABERR] && !mode_reg[UMC_ABD_BIT])
    else $error("auto-rate overflow not flagged");
  err_one_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_WB_ERR |=> !O_WB_ERR)
    else $error("error held");

  // scenarios worth seeing
  wake_cov: cover property (@(posedge I_CLK) wake_arm_reg ##[1:50] wake_clr);
  abd_cov: cover property (@(posedge I_CLK) ab_reg == UMC_AB_DONE);
  loop_cov: cover property (@(posedge I_CLK) mode_reg[UMC_LOOP_BIT] && rx_fall);
  irq_cov: cover property (@(posedge I_CLK) O_IRQ);
  ovf_cov: cover property (@(posedge I_CLK) irq_reg[UMC_IRQ_ABERR]);

endmodule
`default_nettype wire

/* dv/umc_remote_dev.sv */
// remote serial device model driving the receive and clear-to-send pins
`timescale 1ns/100ps
`default_nettype none
module umc_remote_dev (
  // clock
  input  wire logic i_clk,
  // pins
  output logic      o_rx,
  output logic      o_cts
);
  initial begin
    o_rx  = 1'b1;
    o_cts = 1'b1;
  end
  // start, eight bits lsb first, stop; line rests high between frames
  task automatic send_byte(input logic [7:0] b, input int bit_cyc);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rx <= fr[i];
      repeat (bit_cyc) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

/* dv/test_uart_mode_control.sv */
// self-checking bench for the serial mode-control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module test_uart_mode_control;
  import umc_pkg::*;
  logic I_CLK, I_SYS_RST, I_WB_CYC, I_WB_STB, I_WB_WE, O_WB_ACK, O_WB_ERR;
  logic [3:0] I_WB_ADR, I_WB_SEL;
  logic [31:0] I_WB_DAT, O_WB_DAT;
  logic I_IDLE, I_SLEEP, I_CORE_TX, I_CORE_RTS, I_CORE_BCLK, O_CORE_RX;
  logic I_HIGH_SPEED_RATE_SELECT, O_CORE_CTS, O_CORE_RUN, O_IRQ;
  logic O_INFRARED_CODEC_ENABLE, O_REQUEST_PIN_MODE, O_LOOPBACK_SELECT;
  logic I_SERIAL_RECEIVE_PIN, I_CLEAR_TO_SEND_PIN, O_SERIAL_TRANSMIT_PIN;
  logic O_REQUEST_TO_SEND_PIN;
  logic [7:0] O_RATE_COUNT;
  umc_pin_own_type O_PIN_OWN;
  int num_errors = 0;
  int checks = 0;
  int cyc_cnt = 0;
  localparam int BITC = 10;
  // small count width so a slow sync character can overflow it
  umc_mode_ctrl #(.CNT_W(8)) i_dut (.I_CLK, .I_SYS_RST, .I_WB_CYC,
    .I_WB_STB, .I_WB_WE, .I_WB_ADR, .I_WB_SEL, .I_WB_DAT, .O_WB_DAT,
    .O_WB_ACK, .O_WB_ERR, .I_IDLE, .I_SLEEP, .I_CORE_TX, .I_CORE_RTS,
    .I_CORE_BCLK, .I_HIGH_SPEED_RATE_SELECT, .O_CORE_RX, .O_CORE_CTS,
    .O_CORE_RUN, .O_INFRARED_CODEC_ENABLE, .O_REQUEST_PIN_MODE,
    .O_LOOPBACK_SELECT, .O_RATE_COUNT, .I_SERIAL_RECEIVE_PIN,
    .I_CLEAR_TO_SEND_PIN, .O_SERIAL_TRANSMIT_PIN, .O_REQUEST_TO_SEND_PIN,
    .O_PIN_OWN, .O_IRQ);
  umc_remote_dev i_remote (.i_clk(I_CLK), .o_rx(I_SERIAL_RECEIVE_PIN),
    .o_cts(I_CLEAR_TO_SEND_PIN));
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end
  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d,
                    output logic [31:0] q, output logic e);
    I_WB_CYC <= 1'b1;
    I_WB_STB <= 1'b1;
    I_WB_WE  <= w;
    I_WB_ADR <= a;
    I_WB_SEL <= 4'h3;
    I_WB_DAT <= {16'h0000, d};
    // no count here: only the bench timeout ends a hung wait
    do @(posedge I_CLK);
    while (O_WB_ACK !== 1'b1 && O_WB_ERR !== 1'b1);
    q = O_WB_DAT;
    e = O_WB_ERR;
    I_WB_CYC <= 1'b0;
    I_WB_STB <= 1'b0;
    @(posedge I_CLK);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    wb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] x, input string nm);
    logic [31:0] q;
    logic e;
    wb(1'b0, a, 16'h0000, q, e);
    `CHK(nm, x, q[15:0])
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(UMC_MODE_OFS, 16'h0000, "mode at reset");
    `CHK("own at reset", 5'h00, O_PIN_OWN)
    `CHK("tx idle", 1'b1, O_SERIAL_TRANSMIT_PIN)
    wr(UMC_MODE_OFS, 16'hFFDF);
    rd(UMC_MODE_OFS, 16'hBBDF, "gap bits");
    wb(1'b0, 4'h2, 16'h0000, q, e);
    `CHK("unmapped err", 1'b1, e)
    wr(UMC_MODE_OFS, 16'h0000);
  endtask
  task automatic t_pins;
    logic [4:0] tab [4];
    tab = '{5'h18, 5'h1A, 5'h1E, 5'h19};
    // baud clock high, rts low, so the shared pin shows its source
    I_CORE_BCLK <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(UMC_MODE_OFS, 16'h8000 | (16'(s) << UMC_PINSEL_LO));
      repeat (3) @(posedge I_CLK);
      `CHK("pin own", tab[s], O_PIN_OWN)
      `CHK("rts pin", s == 0 || s == 3, O_REQUEST_TO_SEND_PIN)
      `CHK("cts in", s == 2, O_CORE_CTS)
    end
    wr(UMC_MODE_OFS, 16'h0000);
    `CHK("own off", 5'h00, O_PIN_OWN)
    `CHK("run off", 1'b0, O_CORE_RUN)
  endtask
  task automatic t_power;
    wr(UMC_MODE_OFS, 16'hA000);
    I_IDLE <= 1'b1;
    repeat (2) @(posedge I_CLK);
    `CHK("stop idle", 1'b0, O_CORE_RUN)
    wr(UMC_MODE_OFS, 16'h8000);
    `CHK("run idle", 1'b1, O_CORE_RUN)
    rd(UMC_STAT_OFS, 16'h0009, "status run");
    I_IDLE <= 1'b0;
    // infrared only while 16x sampling is selected
    I_HIGH_SPEED_RATE_SELECT <= 1'b0;
    wr(UMC_MODE_OFS, 16'h9800);
    `CHK("ir on", 1'b1, O_INFRARED_CODEC_ENABLE)
    `CHK("simplex", 1'b1, O_REQUEST_PIN_MODE)
    I_HIGH_SPEED_RATE_SELECT <= 1'b1;
    @(posedge I_CLK);
    `CHK("ir gated", 1'b0, O_INFRARED_CODEC_ENABLE)
    I_HIGH_SPEED_RATE_SELECT <= 1'b0;
    wr(UMC_MODE_OFS, 16'h8000);
    `CHK("ir off", 1'b0, O_INFRARED_CODEC_ENABLE)
    `CHK("flow", 1'b0, O_REQUEST_PIN_MODE)
  endtask
  task automatic t_loop;
    wr(UMC_MODE_OFS, 16'h8040);
    `CHK("loop sel", 1'b1, O_LOOPBACK_SELECT)
    for (int v = 0; v < 2; v++) begin
      I_CORE_TX <= v[0];
      repeat (2) @(posedge I_CLK);
      `CHK("loop rx", v[0], O_CORE_RX)
      `CHK("tx pin", v[0], O_SERIAL_TRANSMIT_PIN)
    end
    wr(UMC_MODE_OFS, 16'h8000);
    `CHK("loop off", 1'b0, O_LOOPBACK_SELECT)
  endtask
  task automatic t_wake;
    wr(UMC_MASK_OFS, 16'h0007);
    rd(UMC_MASK_OFS, 16'h0007, "mask");
    wr(UMC_MODE_OFS, 16'h8080);
    I_SLEEP <= 1'b1;
    i_remote.send_byte(8'hFF, BITC);
    repeat (4) @(posedge I_CLK);
    `CHK("wake irq", 1'b1, O_IRQ)
    rd(UMC_MODE_OFS, 16'h8000, "wake cleared");
    wr(UMC_IRQ_OFS, 16'h0001);
    `CHK("irq clear", 1'b0, O_IRQ)
    I_SLEEP <= 1'b0;
  endtask
  task automatic t_rate;
    wr(UMC_MODE_OFS, 16'h8020);
    i_remote.send_byte(UMC_SYNC_CHAR, BITC);
    repeat (4) @(posedge I_CLK);
    rd(UMC_MODE_OFS, 16'h8000, "rate bit done");
    // five falls of the sync character span eight bit times
    `CHK("rate count", 8'(8 * BITC), O_RATE_COUNT)
    rd(UMC_IRQ_OFS, 16'h0002, "rate irq");
    wr(UMC_IRQ_OFS, 16'h0007);
    `CHK("rate irq clr", 1'b0, O_IRQ)
    // a slow sync character outlasts the counter: measurement abandoned
    wr(UMC_MODE_OFS, 16'h8020);
    i_remote.send_byte(UMC_SYNC_CHAR, 4 * BITC);
    repeat (4) @(posedge I_CLK);
    rd(UMC_MODE_OFS, 16'h8000, "rate bit abort");
    rd(UMC_IRQ_OFS, 16'h0004, "overflow irq");
    `CHK("rate kept", 8'(8 * BITC), O_RATE_COUNT)
    wr(UMC_IRQ_OFS, 16'h0004);
    `CHK("ovf irq clr", 1'b0, O_IRQ)
  endtask
  task final_report;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge I_CLK) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      num_errors++;
      final_report;
    end
  end
  initial begin
    {I_WB_CYC, I_WB_STB, I_WB_WE, I_IDLE, I_SLEEP} = 5'h00;
    {I_CORE_RTS, I_CORE_BCLK, I_HIGH_SPEED_RATE_SELECT} = 3'h0;
    I_CORE_TX = 1'b1;
    I_WB_ADR = 4'h0;
    I_WB_SEL = 4'h3;
    I_WB_DAT = 32'h00000000;
    I_SYS_RST = 1'b1;
    repeat (12) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    @(posedge I_CLK);
    t_regs;
    t_pins;
    t_power;
    t_loop;
    t_wake;
    t_rate;
    final_report;
  end
endmodule
`default_nettype wire
